// *** inc/cpe_params.svh ***
// Constants of the current and power calculation engine.
// Assumes inclusion by bare name from rtl and inc files.
`ifndef CPE_PARAMS_SVH
`define CPE_PARAMS_SVH

// ---------------------------------------------------------------
// Register pointer values
// ---------------------------------------------------------------
`define CPE_ADDR_CONFIG 3'h0
`define CPE_ADDR_SHUNT 3'h1
`define CPE_ADDR_BUS 3'h2
`define CPE_ADDR_POWER 3'h3
`define CPE_ADDR_CURRENT 3'h4
`define CPE_ADDR_CAL 3'h5

// ---------------------------------------------------------------
// Reset values and field positions
// ---------------------------------------------------------------
`define CPE_CONFIG_RST 16'h4127
`define CPE_CAL_RST 16'h0000
`define CPE_RESULT_RST 16'h0000
`define CPE_BUS_MSB 15

// ---------------------------------------------------------------
// Arithmetic scaling
// ---------------------------------------------------------------
`define CPE_CUR_SHIFT 11
`define CPE_CUR_DIV 34'sh0_0000_0800
`define CPE_CUR_ROUND 34'sh0_0000_07FF
`define CPE_PWR_DIV 16'h4E20
`define CPE_PWR_RATIO 25
`define CPE_BUS_LSB_UV 1250
`define CPE_DIV_STEPS 6'h20

`endif

// *** inc/cpe_pkg.sv ***
// Types of the current and power calculation engine.
// Assumes nothing beyond a SystemVerilog compiler.
package cpe_pkg;

  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CUR_MUL,
    ST_CUR_STORE,
    ST_PWR_MUL,
    ST_PWR_DIV,
    ST_PWR_WAIT
  } cpe_state_t;

endpackage

// *** inc/cpe_div_if.sv ***
// Handshake between the sequencer and the long divider.
// Assumes the divisor stays stable while a division runs.
`timescale 1ns/1ps

interface cpe_div_if;
  logic start;
  logic busy;
  logic done;
  logic [31:0] dividend;
  logic [15:0] divisor;
  logic [31:0] quotient;

  modport master (
    output start,
    output dividend,
    output divisor,
    input busy,
    input done,
    input quotient
  );

  modport slave (
    input start,
    input dividend,
    input divisor,
    output busy,
    output done,
    output quotient
  );
endinterface

// *** rtl/cpe_mult.sv ***
// Registered signed multiplier for the calculation engine.
// Assumes operands are held one cycle before the product is used.
`timescale 1ns/1ps

module cpe_mult #(
  parameter int AW = 17,
  parameter int BW = 17
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic signed [AW-1:0] a,
  input wire logic signed [BW-1:0] b,
  output logic signed [AW+BW-1:0] p
);

  logic signed [AW+BW-1:0] p_nxt;

  // Full-width product, nothing dropped
  always_comb begin
    p_nxt = a * b;
  end

  // Product register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p <= '0;
    end else begin
      p <= p_nxt;
    end
  end

endmodule

// *** rtl/cpe_divider.sv ***
// Restoring unsigned divider, one quotient bit per clock.
// Assumes start is only raised while busy is low.
`timescale 1ns/1ps
`include "cpe_params.svh"

module cpe_divider (
  input wire logic clk,
  input wire logic rst_n,
  cpe_div_if.slave dv
);

  logic [16:0] rem_r, rem_nxt;
  logic [31:0] quo_r, quo_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic run_r, run_nxt;
  logic done_r, done_nxt;
  logic [16:0] trial;

  // One shift-subtract step per cycle; area traded for latency
  always_comb begin
    rem_nxt = rem_r;
    quo_nxt = quo_r;
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    done_nxt = 1'b0;
    trial = {rem_r[15:0], quo_r[31]};
    if (dv.start && !run_r) begin
      rem_nxt = '0;
      quo_nxt = dv.dividend;
      cnt_nxt = `CPE_DIV_STEPS;
      run_nxt = 1'b1;
    end else if (run_r) begin
      if (trial >= {1'b0, dv.divisor}) begin
        rem_nxt = trial - {1'b0, dv.divisor};
        quo_nxt = {quo_r[30:0], 1'b1};
      end else begin
        rem_nxt = trial;
        quo_nxt = {quo_r[30:0], 1'b0};
      end
      cnt_nxt = cnt_r - 6'h01;
      if (cnt_r == 6'h01) begin
        run_nxt = 1'b0;
        done_nxt = 1'b1;
      end
    end
  end

  // State registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rem_r <= '0;
      quo_r <= '0;
      cnt_r <= '0;
      run_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      rem_r <= rem_nxt;
      quo_r <= quo_nxt;
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
      done_r <= done_nxt;
    end
  end

  assign dv.busy = run_r;
  assign dv.done = done_r;
  assign dv.quotient = quo_r;

  // Division finishes a fixed 33 cycles after it is taken
  a_div_latency: assert property (@(posedge clk) disable iff (!rst_n)
    (dv.start && !run_r) |-> ##33 (done_r && quo_r ==
    $past(dv.dividend, 33) / {16'h0000, $past(dv.divisor, 33)}))
    else $error("divider result late or wrong");

endmodule

// *** rtl/cpe_top.sv ***
// Current and power calculation engine of a shunt monitor.
// Assumes a register port decoded from the serial bus, and one-cycle
// conversion-complete strobes with results from the converter.
`timescale 1ns/1ps
`include "cpe_params.svh"

// Notes on behaviour
// - Current equals shunt result times calibration, divided by 2048.
// - Power equals current magnitude times bus result, divided by 20,000.
// - One power count weighs 25 current counts, fixed internally.
// - Bus result holds the bus voltage at 1.25 mV per count.
// - Top bit of the bus result always reads zero.
// - Current and power stay zero until calibration is written.
// - After calibration, each new shunt result refreshes current and each new bus result refreshes power.
// - Shunt and bus results keep updating with no host programming.
// - Once calibration is written, power is recalculated after every bus conversion completes.
module cpe_top (
  input wire logic CLK_SYS,
  input wire logic NRST,
  input wire logic [2:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [15:0] REG_WDATA,
  input wire logic SHUNT_VALID,
  input wire logic [15:0] SHUNT_IN,
  input wire logic BUS_VALID,
  input wire logic [15:0] BUS_IN,
  output logic [15:0] REG_RDATA,
  output logic [15:0] CONFIG_OUT,
  output logic CAL_VALID,
  output logic CALC_BUSY
);

  // ---------------------------------------------------------------
  // Register read decode
  // ---------------------------------------------------------------
  function automatic logic [15:0] reg_read(
    input logic [2:0] addr,
    input logic [15:0] cfg,
    input logic [15:0] shunt,
    input logic [15:0] bus,
    input logic [15:0] pwr,
    input logic [15:0] cur,
    input logic [15:0] cal
  );
    logic [15:0] val;
    val = 16'h0000;
    case (addr)
      `CPE_ADDR_CONFIG: val = cfg;
      `CPE_ADDR_SHUNT: val = shunt;
      `CPE_ADDR_BUS: val = bus;
      `CPE_ADDR_POWER: val = pwr;
      `CPE_ADDR_CURRENT: val = cur;
      `CPE_ADDR_CAL: val = cal;
      default: val = 16'h0000;
    endcase
    return val;
  endfunction

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  cpe_pkg::cpe_state_t state_r, state_nxt;
  logic [15:0] config_r, config_nxt;
  logic [15:0] cal_r, cal_nxt;
  logic cal_set_r, cal_set_nxt;
  logic [15:0] shunt_r, shunt_nxt;
  logic [15:0] bus_r, bus_nxt;
  logic [15:0] current_r, current_nxt;
  logic [15:0] power_r, power_nxt;
  logic shunt_pend_r, shunt_pend_nxt;
  logic bus_pend_r, bus_pend_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic busy_r, busy_nxt;
  logic signed [16:0] mul_a, mul_b;
  logic signed [33:0] prod;
  logic signed [33:0] cur_round;
  logic [16:0] cur_abs;
  logic take_shunt, take_bus;

  cpe_div_if div_bus ();

  // ---------------------------------------------------------------
  // Arithmetic units
  // ---------------------------------------------------------------
  cpe_mult #(
    .AW(17),
    .BW(17)
  ) u_mult (
    .clk(CLK_SYS),
    .rst_n(NRST),
    .a(mul_a),
    .b(mul_b),
    .p(prod)
  );

  cpe_divider u_div (
    .clk(CLK_SYS),
    .rst_n(NRST),
    .dv(div_bus.slave)
  );

  // Magnitude of current; power is reported unsigned
  assign cur_abs = current_r[15] ? (17'h0_0000 - {current_r[15], current_r})
                                 : {1'b0, current_r};

  // Operand steering shares one multiplier between both results
  always_comb begin
    mul_a = {1'b0, cur_abs[15:0]};
    mul_b = {1'b0, bus_r};
    if (state_r == cpe_pkg::ST_CUR_MUL) begin
      mul_a = {shunt_r[15], shunt_r};
      mul_b = {1'b0, cal_r};
    end else begin
      mul_a = $signed(cur_abs);
    end
  end

  assign cur_round = prod + (prod[33] ? `CPE_CUR_ROUND : 34'sh0_0000_0000);

  // Divider request; divisor fixed so it is stable during a run
  assign div_bus.start = (state_r == cpe_pkg::ST_PWR_DIV);
  assign div_bus.dividend = prod[31:0];
  assign div_bus.divisor = `CPE_PWR_DIV;

  // ---------------------------------------------------------------
  // Measurement capture and register writes
  // ---------------------------------------------------------------
  assign take_shunt = (state_r == cpe_pkg::ST_IDLE) && shunt_pend_r;
  assign take_bus = (state_r == cpe_pkg::ST_IDLE) && !shunt_pend_r &&
                    bus_pend_r;

  // Results land whether or not the host ever programmed anything
  always_comb begin
    config_nxt = config_r;
    cal_nxt = cal_r;
    cal_set_nxt = cal_set_r;
    shunt_nxt = shunt_r;
    bus_nxt = bus_r;
    shunt_pend_nxt = shunt_pend_r;
    bus_pend_nxt = bus_pend_r;
    if (SHUNT_VALID) begin
      shunt_nxt = SHUNT_IN;
    end
    if (BUS_VALID) begin
      bus_nxt = BUS_IN & ~(16'h0001 << `CPE_BUS_MSB);
    end
    if (take_shunt) begin
      shunt_pend_nxt = 1'b0;
    end
    if (take_bus) begin
      bus_pend_nxt = 1'b0;
    end
    if (SHUNT_VALID) begin
      shunt_pend_nxt = 1'b1;
    end
    if (BUS_VALID) begin
      bus_pend_nxt = 1'b1;
    end
    if (REG_WR && REG_ADDR == `CPE_ADDR_CONFIG) begin
      config_nxt = REG_WDATA;
    end
    if (REG_WR && REG_ADDR == `CPE_ADDR_CAL) begin
      cal_nxt = REG_WDATA;
      cal_set_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      config_r <= `CPE_CONFIG_RST;
      cal_r <= `CPE_CAL_RST;
      cal_set_r <= 1'b0;
      shunt_r <= `CPE_RESULT_RST;
      bus_r <= `CPE_RESULT_RST;
      shunt_pend_r <= 1'b0;
      bus_pend_r <= 1'b0;
    end else begin
      config_r <= config_nxt;
      cal_r <= cal_nxt;
      cal_set_r <= cal_set_nxt;
      shunt_r <= shunt_nxt;
      bus_r <= bus_nxt;
      shunt_pend_r <= shunt_pend_nxt;
      bus_pend_r <= bus_pend_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Calculation sequencer
  // ---------------------------------------------------------------
  // Shunt goes first so a waiting bus update uses the fresh current
  always_comb begin
    state_nxt = state_r;
    current_nxt = current_r;
    power_nxt = power_r;
    busy_nxt = 1'b1;
    case (state_r)
      cpe_pkg::ST_IDLE: begin
        busy_nxt = 1'b0;
        if (take_shunt && cal_set_r) begin
          state_nxt = cpe_pkg::ST_CUR_MUL;
          busy_nxt = 1'b1;
        end else if (take_bus && cal_set_r) begin
          state_nxt = cpe_pkg::ST_PWR_MUL;
          busy_nxt = 1'b1;
        end
      end
      cpe_pkg::ST_CUR_MUL: begin
        state_nxt = cpe_pkg::ST_CUR_STORE;
      end
      cpe_pkg::ST_CUR_STORE: begin
        current_nxt = 16'(cur_round >>> `CPE_CUR_SHIFT);
        state_nxt = cpe_pkg::ST_IDLE;
        busy_nxt = 1'b0;
      end
      cpe_pkg::ST_PWR_MUL: begin
        state_nxt = cpe_pkg::ST_PWR_DIV;
      end
      cpe_pkg::ST_PWR_DIV: begin
        state_nxt = cpe_pkg::ST_PWR_WAIT;
      end
      cpe_pkg::ST_PWR_WAIT: begin
        if (div_bus.done) begin
          power_nxt = div_bus.quotient[15:0];
          state_nxt = cpe_pkg::ST_IDLE;
          busy_nxt = 1'b0;
        end
      end
      default: begin
        state_nxt = cpe_pkg::ST_IDLE;
        busy_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      state_r <= cpe_pkg::ST_IDLE;
      current_r <= `CPE_RESULT_RST;
      power_r <= `CPE_RESULT_RST;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      current_r <= current_nxt;
      power_r <= power_nxt;
      busy_r <= busy_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  // Read data is held until the next read strobe
  always_comb begin
    rdata_nxt = rdata_r;
    if (REG_RD) begin
      rdata_nxt = reg_read(REG_ADDR, config_r, shunt_r, bus_r, power_r,
                           current_r, cal_r);
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign REG_RDATA = rdata_r;
  assign CONFIG_OUT = config_r;
  assign CAL_VALID = cal_set_r;
  assign CALC_BUSY = busy_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic signed [33:0] ref_prod;
  logic [15:0] cur_ref;
  logic [15:0] pwr_ref;
  logic [31:0] pwr_prod;

  assign ref_prod = $signed({shunt_r[15], shunt_r}) *
                    $signed({1'b0, cal_r});
  assign cur_ref = 16'(ref_prod / `CPE_CUR_DIV);
  assign pwr_prod = {15'h0000, cur_abs} * {16'h0000, bus_r};
  assign pwr_ref = 16'(pwr_prod / {16'h0000, `CPE_PWR_DIV});

  sequence s_cur_start;
    state_r == cpe_pkg::ST_CUR_MUL;
  endsequence

  sequence s_pwr_start;
    state_r == cpe_pkg::ST_PWR_MUL;
  endsequence

  a_uncal_zero: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    !cal_set_r |-> (current_r == 16'h0000 && power_r == 16'h0000))
    else $error("result nonzero before calibration");

  a_bus_msb_zero: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (REG_RD && REG_ADDR == `CPE_ADDR_BUS) |=> !rdata_r[15])
    else $error("bus result top bit set");

  a_bus_capture: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    BUS_VALID |=> bus_r[14:0] == $past(BUS_IN[14:0]))
    else $error("bus result not captured");

  a_shunt_capture: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    SHUNT_VALID |=> shunt_r == $past(SHUNT_IN))
    else $error("shunt result not captured");

  a_cur_value: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    s_cur_start |-> ##2 (current_r == $past(cur_ref, 2)))
    else $error("current value wrong");

  a_pwr_value: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    s_pwr_start |-> ##35 (power_r == $past(pwr_ref, 35)))
    else $error("power value wrong");

  a_bus_starts_pwr: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (take_bus && cal_set_r) |=> s_pwr_start)
    else $error("bus update did not start power");

  a_cal_refresh: assert property (@(posedge CLK_SYS) disable iff (!NRST)
    (SHUNT_VALID && cal_set_r && state_r == cpe_pkg::ST_IDLE &&
    !shunt_pend_r) |=> ##[1:2] s_cur_start)
    else $error("shunt update did not refresh current");

endmodule

// *** dv/cpe_host_model.sv ***
// Host controller model: register strobes and calibration arithmetic.
// Assumes the engine's one-cycle read and write strobe port.
`timescale 1ns/1ps

module cpe_host_model (
  input wire logic clk,
  output logic [2:0] addr,
  output logic wr,
  output logic rd,
  output logic [15:0] wdata,
  input wire logic [15:0] rdata
);
  // Idle bus at time zero
  initial begin
    addr = 3'h0;
    wr = 1'b0;
    rd = 1'b0;
    wdata = 16'h0000;
  end

  // Write strobe; data scrambled once released so stale data is not reused
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask

  // Read strobe; data sampled just after the answering edge
  task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  function automatic real step_a(input real imax_a);
    return $ceil(imax_a / 32768.0 * 1000.0) / 1000.0;
  endfunction

  function automatic logic [15:0] cal_of(input real step, input real r);
    return 16'($rtoi(0.00512 / (step * r) + 0.5));
  endfunction

  function automatic logic [15:0] cal_fix(input logic [15:0] cal,
                                          input logic [15:0] meas,
                                          input logic [15:0] seen);
    return 16'((int'(cal) * int'(meas)) / int'(seen));
  endfunction
endmodule

// *** dv/cpe_top_tb.sv ***
// Self-checking bench of the current and power calculation engine.
// Assumes the host model in cpe_host_model and a 100 MHz clock.
`timescale 1ns/1ps

module cpe_top_tb;
  // ---------------------------------------------------------------
  // Stimulus, wiring and checking helpers
  // ---------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic shunt_valid = 1'b0;
  logic bus_valid = 1'b0;
  logic [15:0] shunt_in = 16'h0000;
  logic [15:0] bus_in = 16'h0000;
  logic [2:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [15:0] config_out;
  logic [15:0] rd_val;
  logic [15:0] cur;
  logic [15:0] c;
  logic cal_valid;
  logic calc_busy;
  int fails = 0;
  int n_tests = 0;
  logic [15:0] sh [4] = '{16'h1F40, 16'hE0C0, 16'h0001, 16'hFFFF};
  logic [15:0] bu [4] = '{16'h2570, 16'hFFFF, 16'h8001, 16'h2570};

  // Free-running system clock
  always #5 clk_sys = ~clk_sys;

  cpe_top DUT (
    .CLK_SYS(clk_sys),
    .NRST(nrst),
    .REG_ADDR(reg_addr),
    .REG_WR(reg_wr),
    .REG_RD(reg_rd),
    .REG_WDATA(reg_wdata),
    .SHUNT_VALID(shunt_valid),
    .SHUNT_IN(shunt_in),
    .BUS_VALID(bus_valid),
    .BUS_IN(bus_in),
    .REG_RDATA(reg_rdata),
    .CONFIG_OUT(config_out),
    .CAL_VALID(cal_valid),
    .CALC_BUSY(calc_busy)
  );

  cpe_host_model host (
    .clk(clk_sys),
    .addr(reg_addr),
    .wr(reg_wr),
    .rd(reg_rd),
    .wdata(reg_wdata),
    .rdata(reg_rdata)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Current truncates toward zero, kept as 16 bits
  function automatic logic [15:0] exp_cur(input logic [15:0] s,
                                          input logic [15:0] k);
    return 16'(($signed(s) * int'(k)) / 2048);
  endfunction

  // Power uses the magnitude of the signed current
  function automatic logic [15:0] exp_pwr(input logic [15:0] i,
                                          input logic [15:0] b);
    int m;
    m = $signed(i);
    if (m < 0)
      m = -m;
    return 16'((m * int'(b)) / 20000);
  endfunction

  // Converter strobes, then a bounded wait for the engine to go idle
  task automatic meas(input logic ds, input logic db,
                      input logic [15:0] s, input logic [15:0] b);
    int n;
    int quiet;
    @(posedge clk_sys);
    shunt_valid <= ds;
    bus_valid <= db;
    shunt_in <= s;
    bus_in <= b;
    @(posedge clk_sys);
    shunt_valid <= 1'b0;
    bus_valid <= 1'b0;
    shunt_in <= ~s;
    bus_in <= ~b;
    n = 0;
    quiet = 0;
    repeat (3) @(negedge clk_sys);
    // Busy dips for one cycle between a current and a queued power run
    while (quiet < 2 && n < 80) begin
      quiet = (calc_busy === 1'b0) ? quiet + 1 : 0;
      n++;
      @(negedge clk_sys);
    end
    if (quiet < 2)
      check(16'h0001, 16'h0000);
  endtask

  // Watchdog: the tests need well under 20 us
  initial begin
    #200_000;
    fails++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      host.rd_reg(3'(a), rd_val);
      check(rd_val, (a == 0) ? 16'h4127 : 16'h0000);
    end
    check({15'h0000, cal_valid}, 16'h0000);
    done("defaults");

    meas(1'b1, 1'b1, 16'h1F40, 16'h2570);
    host.wr_reg(3'h4, 16'h1234);
    host.rd_reg(3'h1, rd_val);
    check(rd_val, 16'h1F40);
    host.rd_reg(3'h2, rd_val);
    check(rd_val, 16'($rtoi(11.98 / 0.00125 + 0.5)));
    host.rd_reg(3'h4, rd_val);
    check(rd_val, 16'h0000);
    host.rd_reg(3'h3, rd_val);
    check(rd_val, 16'h0000);
    host.wr_reg(3'h0, 16'h4527);
    host.rd_reg(3'h0, rd_val);
    check(rd_val, 16'h4527);
    check(config_out, 16'h4527);
    done("uncalibrated");

    c = host.cal_of(host.step_a(15.0), 0.002);
    check(c, 16'h0A00);
    host.wr_reg(3'h5, c);
    @(negedge clk_sys);
    check({15'h0000, cal_valid}, 16'h0001);
    meas(1'b1, 1'b0, 16'h1F40, 16'h0000);
    host.rd_reg(3'h4, cur);
    check(cur, 16'h2710);
    meas(1'b0, 1'b1, 16'h0000, 16'h2570);
    host.rd_reg(3'h3, rd_val);
    check(rd_val, 16'h12B8);
    check(rd_val, 16'($rtoi(10.0 * 11.98 / 0.025 + 0.001)));
    done("calibrated");

    c = host.cal_fix(c, 16'h2904, cur);
    check(c, 16'h0A80);
    host.wr_reg(3'h5, c);
    foreach (sh[k]) begin
      meas(1'b1, 1'b1, sh[k], bu[k]);
      host.rd_reg(3'h4, cur);
      check(cur, exp_cur(sh[k], c));
      host.rd_reg(3'h2, rd_val);
      check(rd_val, {1'b0, bu[k][14:0]});
      host.rd_reg(3'h3, rd_val);
      check(rd_val, exp_pwr(exp_cur(sh[k], c), {1'b0, bu[k][14:0]}));
    end
    done("corrected");

    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    host.rd_reg(3'h5, rd_val);
    check(rd_val, 16'h0000);
    meas(1'b1, 1'b1, 16'h1F40, 16'h2570);
    host.rd_reg(3'h4, rd_val);
    check(rd_val, 16'h0000);
    check({15'h0000, cal_valid}, 16'h0000);
    host.wr_reg(3'h5, c);
    meas(1'b1, 1'b0, 16'h1F40, 16'h0000);
    host.rd_reg(3'h4, rd_val);
    check(rd_val, exp_cur(16'h1F40, c));
    done("power_up");
    report_and_stop();
  end
endmodule
